/* File: sppf_forwarding_ctrl.sv */
`timescale 1ns/1ns
// Function
// - one 8-bit traffic register per port 0..7 at indices 00h to 07h
// - port bits 7:5 hold software-written spanning tree state, codes 000 to 111
// - spanning tree default is none when strap set, disabled otherwise
// - port bit 1 set stops MAC transmit; reset zero
// - port bit 0 set stops MAC receive; reset zero
// - unicast copy bit passes table-matched unicast to management port when selected
// - unicast copy clear: only mirror-matched unicast reaches management port
// - multicast copy bit passes flooded multicast to management port when selected
// - multicast copy clear: only mirror-matched multicast reaches management port
// - broadcast copy bit passes broadcast to management port when selected
// - forwarding enable bit gates all forwarding; default equals strap
// - mode bit 0 picks unmanaged or managed; default inverse of strap
module sppf_forwarding_ctrl (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // strap pin
  input  wire logic                forwarding_strap,
  // axi4-lite write address and data
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // per port controls
  output logic [7:0][2:0]          span_tree_state,
  output logic [7:0]               mac_transmit_off,
  output logic [7:0]               mac_receive_off,
  // switch controls
  output logic                     frame_pass_enable,
  output logic                     managed_select,
  output logic                     config_ready,
  // management copy decision
  input  wire logic                frm_valid,
  input  wire logic [1:0]          frm_kind,
  input  wire logic                frm_table_hit,
  input  wire logic                frm_mirror_hit,
  input  wire logic                mgmt_is_frame_port,
  output logic                     mgmt_copy
);
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } sppf_init_e;

  sppf_init_e  st;
  logic        strap_s1;
  logic        strap_s2;
  logic        strap_s3;
  logic [1:0]  settle;
  logic        aw_held;
  logic        aw_ok;
  logic [3:0]  aw_idx;
  logic        w_held;
  logic [7:0]  w_byte;
  logic        w_lane;
  logic        do_write;
  logic        wr_hit;
  logic [3:0]  rd_idx;
  logic        ar_ok;
  logic        ar_pend;
  logic [7:0]  rd_byte;
  logic        ucast;
  logic        mcast;
  logic        bcast;
  logic [7:0]  port_val [sppf_pkg::PORTS];

  sppf_port_if pif [sppf_pkg::PORTS] ();

  // strap synchroniser, first stage read only by the second
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_s3 <= 1'b0;
    end else begin
      strap_s1 <= forwarding_strap;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  // init sequence: settle strap, load defaults once, then serve the bus
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st     <= ST_WAIT;
      settle <= 2'h0;
    end else begin
      unique case (st)
        ST_WAIT: begin
          if (settle != sppf_pkg::SETTLE_CNT) begin
            settle <= settle + 2'h1;
          end else if (strap_s2 == strap_s3) begin
            st <= ST_LOAD;
          end
        end
        ST_LOAD: st <= ST_RUN;
        ST_RUN:  st <= ST_RUN;
        default: st <= ST_WAIT;
      endcase
    end
  end

  // bus opens once defaults are in place
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_ready <= 1'b0;
    end else begin
      config_ready <= (st == ST_LOAD) || (st == ST_RUN);
    end
  end

  // map check for the word index
  function automatic logic idx_mapped(input logic [31:0] addr);
    logic [3:0] idx;
    idx = addr[sppf_pkg::ADDR_MSB:sppf_pkg::ADDR_LSB];
    idx_mapped = (addr[31:sppf_pkg::ADDR_MSB+1] == 26'h0) &&
                 ((idx <= sppf_pkg::IDX_PORT7) || (idx == sppf_pkg::IDX_MGMT) ||
                  (idx == sppf_pkg::IDX_MODE));
  endfunction

  // write address channel
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b0;
      aw_ok         <= 1'b0;
      aw_idx        <= 4'h0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b1;
      aw_ok         <= idx_mapped(s_axi_awaddr);
      aw_idx        <= s_axi_awaddr[sppf_pkg::ADDR_MSB:sppf_pkg::ADDR_LSB];
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
      end
      s_axi_awready <= (st == ST_RUN) && !aw_held && !s_axi_bvalid;
    end
  end

  // write data channel
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b0;
      w_byte       <= 8'h00;
      w_lane       <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b1;
      w_byte       <= s_axi_wdata[7:0];
      w_lane       <= s_axi_wstrb[0];
    end else begin
      if (do_write) begin
        w_held <= 1'b0;
      end
      s_axi_wready <= (st == ST_RUN) && !w_held && !s_axi_bvalid;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit   = do_write && aw_ok && w_lane;

  // write response, one outstanding write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sppf_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_ok ? sppf_pkg::RESP_OKAY : sppf_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // per port registers, one instance each
  for (genvar g = 0; g < sppf_pkg::PORTS; g++) begin : g_port
    assign pif[g].wr_en   = wr_hit && (aw_idx == 4'(g));
    assign pif[g].load_en = (st == ST_LOAD);
    assign pif[g].strap   = strap_s3;
    assign pif[g].wdata   = w_byte;
    assign port_val[g]    = pif[g].value;
    assign span_tree_state[g]  = pif[g].value[sppf_pkg::STP_HI:sppf_pkg::STP_LO];
    assign mac_transmit_off[g] = pif[g].value[sppf_pkg::TXOFF_BIT];
    assign mac_receive_off[g]  = pif[g].value[sppf_pkg::RXOFF_BIT];
    sppf_port_ctrl u_port (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pif      (pif[g])
    );
  end

  // management copy enables; reserved bits are not stored
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ucast <= 1'b0;
      mcast <= 1'b0;
      bcast <= 1'b0;
    end else if (wr_hit && aw_idx == sppf_pkg::IDX_MGMT) begin
      ucast <= w_byte[sppf_pkg::UCAST_BIT];
      mcast <= w_byte[sppf_pkg::MCAST_BIT];
      bcast <= w_byte[sppf_pkg::BCAST_BIT];
    end
  end

  // switch mode: strap defaults at load, software after
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_pass_enable <= 1'b0;
      managed_select    <= 1'b1;
    end else if (st == ST_LOAD) begin
      frame_pass_enable <= strap_s3;
      managed_select    <= !strap_s3;
    end else if (wr_hit && aw_idx == sppf_pkg::IDX_MODE) begin
      frame_pass_enable <= w_byte[sppf_pkg::PASS_BIT];
      managed_select    <= w_byte[sppf_pkg::MANAGED_BIT];
    end
  end

  // read data selection
  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx <= sppf_pkg::IDX_PORT7) begin
      rd_byte = port_val[rd_idx[2:0]];
    end else if (rd_idx == sppf_pkg::IDX_MGMT) begin
      rd_byte = {3'h0, ucast, mcast, bcast, 2'h0};
    end else if (rd_idx == sppf_pkg::IDX_MODE) begin
      rd_byte = {sppf_pkg::MODE_RSVD, frame_pass_enable, managed_select};
    end
  end

  // read address capture, one outstanding read
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      rd_idx        <= 4'h0;
      ar_ok         <= 1'b0;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      rd_idx        <= s_axi_araddr[sppf_pkg::ADDR_MSB:sppf_pkg::ADDR_LSB];
      ar_ok         <= idx_mapped(s_axi_araddr);
    end else begin
      s_axi_arready <= (st == ST_RUN) && !s_axi_rvalid && !ar_pend;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ar_pend      <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= sppf_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      ar_pend <= 1'b1;
    end else if (ar_pend) begin
      ar_pend      <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= ar_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      s_axi_rresp  <= ar_ok ? sppf_pkg::RESP_OKAY : sppf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // copy to the management port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_copy <= 1'b0;
    end else begin
      mgmt_copy <= frm_valid && frame_pass_enable &&
        (frm_mirror_hit ||
         (mgmt_is_frame_port &&
          ((frm_kind == sppf_pkg::KIND_UNI && frm_table_hit && ucast) ||
           (frm_kind == sppf_pkg::KIND_MULTI && !frm_table_hit && mcast) ||
           (frm_kind == sppf_pkg::KIND_BROAD && bcast))));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  bus_closed_init_a: assert property (st != ST_RUN |-> !s_axi_awready && !s_axi_arready)
    else $error("bus open before defaults loaded");
  write_answer_a: assert property (do_write |=> s_axi_bvalid &&
    s_axi_bresp == ($past(aw_ok) ? sppf_pkg::RESP_OKAY : sppf_pkg::RESP_SLVERR))
    else $error("write answer wrong");
  mode_strap_a: assert property (st == ST_LOAD |=>
    frame_pass_enable == $past(strap_s3) && managed_select == !$past(strap_s3))
    else $error("mode defaults do not follow strap");
  mode_write_a: assert property (wr_hit && aw_idx == sppf_pkg::IDX_MODE && st == ST_RUN |=>
    frame_pass_enable == $past(w_byte[1]) && managed_select == $past(w_byte[0]))
    else $error("mode write lost");
  mode_reserved_a: assert property ($rose(s_axi_rvalid) && ar_ok && rd_idx == sppf_pkg::IDX_MODE
    |-> s_axi_rdata[7:2] == sppf_pkg::MODE_RSVD)
    else $error("mode reserved bits wrong");
  pass_gate_a: assert property (!frame_pass_enable |=> !mgmt_copy)
    else $error("copy while forwarding off");
  bcast_copy_a: assert property (frm_valid && frame_pass_enable && mgmt_is_frame_port && bcast &&
    frm_kind == sppf_pkg::KIND_BROAD |=> mgmt_copy)
    else $error("broadcast not copied");
  ucast_mirror_a: assert property (frm_valid && frm_kind == sppf_pkg::KIND_UNI &&
    !frm_mirror_hit && !ucast |=> !mgmt_copy)
    else $error("unicast copied without mirror");
  mcast_flood_a: assert property (frm_valid && frame_pass_enable && mgmt_is_frame_port && mcast &&
    frm_kind == sppf_pkg::KIND_MULTI && !frm_table_hit |=> mgmt_copy)
    else $error("flooded multicast not copied");
endmodule // sppf_forwarding_ctrl

/* File: sppf_pkg.sv */
package sppf_pkg;
  // port count and register indices; byte address is four times the index
  localparam int unsigned PORTS      = 8;
  localparam logic [3:0]  IDX_PORT0  = 4'h0;
  localparam logic [3:0]  IDX_PORT7  = 4'h7;
  localparam logic [3:0]  IDX_MGMT   = 4'h8;
  localparam logic [3:0]  IDX_MODE   = 4'hb;
  localparam int unsigned ADDR_LSB   = 2;
  localparam int unsigned ADDR_MSB   = 5;

  // port register fields
  localparam int unsigned STP_HI     = 7;
  localparam int unsigned STP_LO     = 5;
  localparam int unsigned TXOFF_BIT  = 1;
  localparam int unsigned RXOFF_BIT  = 0;
  localparam logic [2:0]  STP_NONE     = 3'h0;
  localparam logic [2:0]  STP_DISABLED = 3'h1;
  localparam logic [2:0]  PORT_RSVD    = 3'h0;

  // management copy register fields
  localparam int unsigned UCAST_BIT  = 4;
  localparam int unsigned MCAST_BIT  = 3;
  localparam int unsigned BCAST_BIT  = 2;

  // switch mode register fields
  localparam int unsigned PASS_BIT    = 1;
  localparam int unsigned MANAGED_BIT = 0;
  localparam logic [5:0]  MODE_RSVD   = 6'h01;

  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // frame classes seen by the copy decision
  localparam logic [1:0]  KIND_UNI   = 2'h0;
  localparam logic [1:0]  KIND_MULTI = 2'h1;
  localparam logic [1:0]  KIND_BROAD = 2'h2;

  // strap synchroniser settle count
  localparam logic [1:0]  SETTLE_CNT = 2'h3;
endpackage

/* File: sppf_port_ctrl.sv */
`timescale 1ns/1ns
module sppf_port_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register access
  sppf_port_if.ctrl pif
);
  logic [2:0] stp;
  logic       tx_off;
  logic       rx_off;

  // state, strap default once after reset, then software writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stp    <= sppf_pkg::STP_DISABLED;
      tx_off <= 1'b0;
      rx_off <= 1'b0;
    end else if (pif.load_en) begin
      stp    <= pif.strap ? sppf_pkg::STP_NONE : sppf_pkg::STP_DISABLED;
      tx_off <= 1'b0;
      rx_off <= 1'b0;
    end else if (pif.wr_en) begin
      stp    <= pif.wdata[sppf_pkg::STP_HI:sppf_pkg::STP_LO];
      tx_off <= pif.wdata[sppf_pkg::TXOFF_BIT];
      rx_off <= pif.wdata[sppf_pkg::RXOFF_BIT];
    end
  end

  // reserved bits always read as zero
  assign pif.value = {stp, sppf_pkg::PORT_RSVD, tx_off, rx_off};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  strap_default_a: assert property (pif.load_en |=>
    stp == ($past(pif.strap) ? sppf_pkg::STP_NONE : sppf_pkg::STP_DISABLED))
    else $error("port state default does not follow strap");
  mac_off_write_a: assert property (pif.wr_en && !pif.load_en |=>
    tx_off == $past(pif.wdata[1]) && rx_off == $past(pif.wdata[0]))
    else $error("mac on off bits not written");
endmodule // sppf_port_ctrl

/* File: sppf_port_if.sv */
`timescale 1ns/1ns
interface sppf_port_if;
  logic       wr_en;
  logic       load_en;
  logic       strap;
  logic [7:0] wdata;
  logic [7:0] value;
  modport ctrl (input wr_en, input load_en, input strap, input wdata, output value);
  modport bank (output wr_en, output load_en, output strap, output wdata, input value);
endinterface

/* File: switch_port_forwarding_control_tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module switch_port_forwarding_control_tb;
  logic            core_clk;
  logic            reset_n;
  logic            forwarding_strap;
  logic [31:0]     s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]      s_axi_wstrb;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready;
  logic [7:0][2:0] span_tree_state;
  logic [7:0]      mac_transmit_off, mac_receive_off;
  logic            frame_pass_enable, managed_select, config_ready;
  logic            frm_valid, frm_table_hit, frm_mirror_hit, mgmt_is_frame_port, mgmt_copy;
  logic [1:0]      frm_kind;
  int              err_count;
  int              num_checks;

  sppf_forwarding_ctrl sppf_forwarding_ctrl_i (
    .core_clk(core_clk), .reset_n(reset_n), .forwarding_strap(forwarding_strap),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .span_tree_state(span_tree_state), .mac_transmit_off(mac_transmit_off),
    .mac_receive_off(mac_receive_off), .frame_pass_enable(frame_pass_enable),
    .managed_select(managed_select), .config_ready(config_ready), .frm_valid(frm_valid),
    .frm_kind(frm_kind), .frm_table_hit(frm_table_hit), .frm_mirror_hit(frm_mirror_hit),
    .mgmt_is_frame_port(mgmt_is_frame_port), .mgmt_copy(mgmt_copy));

  // free running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // counts and verdict
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // reset with a given strap level, then wait for defaults to load
  task automatic do_reset(input logic strap);
    int n;
    n = 0;
    forwarding_strap <= strap;
    reset_n          <= 1'b0;
    repeat (5) @(posedge core_clk);
    `CHK(config_ready, 1'b0)
    reset_n <= 1'b1;
    while (config_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(config_ready, 1'b1)
    @(posedge core_clk);
  endtask

  // one write: address and data offered together, held until each is taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    `CHK(s_axi_bvalid, 1'b1)
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  // one read, compared against the expected byte and response
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    `CHK(s_axi_rvalid, 1'b1)
    `CHK({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e})
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // one frame decision, answer looked at in the cycle after it is taken
  task automatic frm(input logic [1:0] k, input logic h, m, p, e);
    frm_valid          <= 1'b1;
    frm_kind           <= k;
    frm_table_hit      <= h;
    frm_mirror_hit     <= m;
    mgmt_is_frame_port <= p;
    @(posedge core_clk);
    frm_valid <= 1'b0;
    #1 `CHK(mgmt_copy, e)
    @(posedge core_clk);
  endtask

  // defaults after reset for one strap level
  task automatic t_defaults(input logic strap);
    logic [2:0] st;
    st = strap ? 3'h0 : 3'h1;
    do_reset(strap);
    `CHK(frame_pass_enable, strap)
    `CHK(managed_select, ~strap)
    for (int i = 0; i < 8; i++) begin
      `CHK({span_tree_state[i], mac_transmit_off[i], mac_receive_off[i]}, {st, 2'h0})
      rd_chk(32'(i * 4), {st, 5'h00}, sppf_pkg::RESP_OKAY);
    end
    rd_chk(32'h20, 8'h00, sppf_pkg::RESP_OKAY);
    rd_chk(32'h2c, {6'h01, strap, ~strap}, sppf_pkg::RESP_OKAY);
  endtask

  // every state code and both off bits per port, reserved bits written high
  task automatic t_ports();
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      wr(32'(i * 4), {3'(i), 3'h7, 2'(i)}, 4'hf, r);
      `CHK(r, sppf_pkg::RESP_OKAY)
      `CHK({span_tree_state[i], mac_transmit_off[i], mac_receive_off[i]}, {3'(i), 2'(i)})
      rd_chk(32'(i * 4), {3'(i), 3'h0, 2'(i)}, sppf_pkg::RESP_OKAY);
    end
  endtask

  // copy controls all set, all clear, then one bit at a time, against all frame classes
  task automatic t_mgmt();
    logic [7:0] cfg [5] = '{8'hff, 8'he3, 8'h10, 8'h08, 8'h04};
    logic [1:0] r, k;
    logic       h, m, p, e;
    for (int c = 0; c < 5; c++) begin
      wr(32'h20, cfg[c], 4'hf, r);
      rd_chk(32'h20, cfg[c] & 8'h1c, sppf_pkg::RESP_OKAY);
      for (int n = 0; n < 24; n++) begin
        k = 2'(n % 3);
        h = 1'((n / 3) % 2);
        m = 1'((n / 6) % 2);
        p = 1'(n / 12);
        e = m | (p & ((k == 2'h0 & h & cfg[c][4]) | (k == 2'h1 & !h & cfg[c][3])
                    | (k == 2'h2 & cfg[c][2])));
        frm(k, h, m, p, e);
      end
    end
  endtask

  // forwarding off stops a mirrored broadcast copy; reserved mode bits stay fixed
  task automatic t_mode();
    logic [1:0] r;
    wr(32'h2c, 8'hfc, 4'hf, r);
    `CHK({frame_pass_enable, managed_select}, 2'h0)
    rd_chk(32'h2c, 8'h04, sppf_pkg::RESP_OKAY);
    frm(2'h2, 1'b1, 1'b1, 1'b1, 1'b0);
    wr(32'h2c, 8'h03, 4'hf, r);
    `CHK({frame_pass_enable, managed_select}, 2'h3)
    rd_chk(32'h2c, 8'h07, sppf_pkg::RESP_OKAY);
  endtask

  // unmapped place and a write with its byte lane off
  task automatic t_bus();
    logic [1:0] r;
    wr(32'h24, 8'hff, 4'hf, r);
    `CHK(r, sppf_pkg::RESP_SLVERR)
    rd_chk(32'h24, 8'h00, sppf_pkg::RESP_SLVERR);
    wr(32'h1c, 8'h00, 4'he, r);
    `CHK(r, sppf_pkg::RESP_OKAY)
    rd_chk(32'h1c, 8'he3, sppf_pkg::RESP_OKAY);
  endtask

  // managed start: forwarding kept off while copy bits are set up, then enabled
  task automatic t_managed();
    logic [1:0] r;
    wr(32'h20, 8'h04, 4'hf, r);
    `CHK(frame_pass_enable, 1'b0)
    frm(2'h2, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(32'h2c, 8'h03, 4'hf, r);
    `CHK({frame_pass_enable, managed_select}, 2'h3)
    frm(2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
  endtask

  // main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    reset_n = 1'b0;
    forwarding_strap = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {frm_valid, frm_kind, frm_table_hit, frm_mirror_hit, mgmt_is_frame_port} = '0;
    t_defaults(1'b1);
    t_ports();
    t_mgmt();
    t_mode();
    t_bus();
    t_defaults(1'b0);
    t_managed();
    wrap_up();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
endmodule // switch_port_forwarding_control_tb
